/* dv/emulated_nv_byte_store_tb.sv */
/*
  Self-checking testbench for the emulated non-volatile byte store.
  Assumes the design from hdl/ and its package are compiled first and
  that one register access is presented per cycle on the core port.
*/
`timescale 1ns/1ps
`default_nettype none

module emulated_nv_byte_store_tb;
  import nv_store_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic       ref_clk_i = 1'b0;          // core clock, 40 ns, owned by the clock process
  logic       rst_i;                     // power-on reset
  sfr_req_t   sfr_i;                     // register access
  logic [7:0] sfr_rdata_o;               // read data
  logic       busy_o;                    // transfer running
  int         bad_count;                 // mismatches
  int         n_checks;                  // comparisons made

  emulated_nv_byte_store DUT
  (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .sfr_i       (sfr_i),
    .sfr_rdata_o (sfr_rdata_o),
    .busy_o      (busy_o)
  );

  // clock: invert after each half period
  always #20 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // print the counts and the verdict, then stop
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // compare one byte value
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %02h seen %02h", what, exp, got);
    end
  endtask : chk

  // one register write, strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_i <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge ref_clk_i);
    sfr_i <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: d};
  endtask : wr

  // one register read; data is settled just after the edge that takes it
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    sfr_i <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge ref_clk_i);
    sfr_i <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    #1;
    chk(what, exp, sfr_rdata_o);
  endtask : rchk

  // issue a transfer command and count the busy cycles, bounded
  task automatic run_cmd(input logic [7:0] c);
    int n;
    wr(NV_CONTROL_OFF, c);
    #1;
    n = 0;
    while (busy_o !== 1'b0 && n < 100)
    begin
      n++;
      @(posedge ref_clk_i);
      #1;
    end
    chk("busy cycles", 8'h20, 8'(n));
  endtask : run_cmd

  // synchronous reset held for four edges
  task automatic do_reset;
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values of every register
  task automatic t_reset_values;
    rchk("index reset", BYTE_INDEX_OFF, 8'h00);
    rchk("control reset", NV_CONTROL_OFF, 8'h00);
    rchk("guard reset", UNLOCK_KEY_OFF, 8'h00);
    rchk("data disabled", BYTE_VALUE_OFF, 8'h00);
    rchk("unmapped", 8'hC4, 8'h00);
  endtask : t_reset_values

  // upper index bits read zero and ignore writes
  task automatic t_index_field;
    wr(BYTE_INDEX_OFF, 8'hFF);
    rchk("index field", BYTE_INDEX_OFF, 8'h1F);
  endtask : t_index_field

  // with the logic off, a data write neither lands nor steps
  task automatic t_disabled;
    wr(BYTE_INDEX_OFF, 8'h03);
    wr(NV_CONTROL_OFF, 8'h01);
    wr(BYTE_VALUE_OFF, 8'h5A);
    rchk("index no step", BYTE_INDEX_OFF, 8'h03);
    wr(NV_CONTROL_OFF, 8'h80);
    rchk("dropped write", BYTE_VALUE_OFF, 8'h00);
  endtask : t_disabled

  // fill all 32 bytes with auto-step, wrap, then read them back
  task automatic t_fill_step;
    wr(NV_CONTROL_OFF, 8'h81);
    wr(BYTE_INDEX_OFF, 8'h00);
    for (int i = 0; i < IMAGE_BYTES; i++)
      wr(BYTE_VALUE_OFF, 8'hA0 ^ 8'(i));
    rchk("index wrap", BYTE_INDEX_OFF, 8'h00);
    wr(BYTE_INDEX_OFF, 8'h1F);
    rchk("top byte", BYTE_VALUE_OFF, 8'hBF);
    rchk("read wrap", BYTE_INDEX_OFF, 8'h00);
    for (int i = 0; i < IMAGE_BYTES; i++)
      rchk("image byte", BYTE_VALUE_OFF, 8'hA0 ^ 8'(i));
  endtask : t_fill_step

  // keyed store, relock, clobber image, load back from the array
  task automatic t_store_load;
    wr(UNLOCK_KEY_OFF, KEY_FIRST);
    rchk("guard half", UNLOCK_KEY_OFF, 8'h01);
    rchk("guard reread", UNLOCK_KEY_OFF, 8'h01);
    wr(UNLOCK_KEY_OFF, KEY_SECOND);
    rchk("guard open", UNLOCK_KEY_OFF, 8'h02);
    run_cmd(8'h83);
    rchk("guard relock", UNLOCK_KEY_OFF, 8'h00);
    rchk("store bit clear", NV_CONTROL_OFF, 8'h81);
    for (int i = 0; i < IMAGE_BYTES; i++)
      wr(BYTE_VALUE_OFF, 8'h00);
    rchk("clobbered", BYTE_VALUE_OFF, 8'h00);
    run_cmd(8'h85);
    rchk("load bit clear", NV_CONTROL_OFF, 8'h81);
    wr(BYTE_INDEX_OFF, 8'h00);
    for (int i = 0; i < IMAGE_BYTES; i++)
      rchk("loaded byte", BYTE_VALUE_OFF, 8'hA0 ^ 8'(i));
  endtask : t_store_load

  // store without keys locks until power-on; keys no longer help
  task automatic t_penalty;
    wr(NV_CONTROL_OFF, 8'h83);
    #1;
    chk("no busy", 8'h00, {7'h00, busy_o});
    rchk("guard dead", UNLOCK_KEY_OFF, 8'h03);
    wr(UNLOCK_KEY_OFF, KEY_FIRST);
    wr(UNLOCK_KEY_OFF, KEY_SECOND);
    rchk("guard stays dead", UNLOCK_KEY_OFF, 8'h03);
    do_reset();
    rchk("guard after reset", UNLOCK_KEY_OFF, 8'h00);
  endtask : t_penalty

  // load wins over store when both bits are written; spoiled keys lock
  task automatic t_overlap;
    wr(UNLOCK_KEY_OFF, KEY_FIRST);
    wr(UNLOCK_KEY_OFF, KEY_SECOND);
    run_cmd(8'h86);
    rchk("no store penalty", UNLOCK_KEY_OFF, 8'h02);
    rchk("both bits clear", NV_CONTROL_OFF, 8'h80);
    wr(BYTE_INDEX_OFF, 8'h05);
    rchk("reloaded byte", BYTE_VALUE_OFF, 8'hA5);
    wr(UNLOCK_KEY_OFF, KEY_FIRST);
    rchk("key while open", UNLOCK_KEY_OFF, 8'h03);
    do_reset();
    wr(UNLOCK_KEY_OFF, KEY_FIRST);
    wr(NV_CONTROL_OFF, 8'h82);
    rchk("store half keyed", UNLOCK_KEY_OFF, 8'h03);
    do_reset();
  endtask : t_overlap

  // a wrong second key byte locks as well
  task automatic t_wrong_key;
    wr(UNLOCK_KEY_OFF, KEY_FIRST);
    wr(UNLOCK_KEY_OFF, 8'h12);
    rchk("guard wrong key", UNLOCK_KEY_OFF, 8'h03);
    do_reset();
  endtask : t_wrong_key

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    rst_i     = 1'b1;
    sfr_i     = '0;
    bad_count = 0;
    n_checks  = 0;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_index_field();
    t_disabled();
    t_fill_step();
    t_store_load();
    t_penalty();
    t_overlap();
    t_wrong_key();
    end_of_test();
  end

  // the run needs well under 2000 cycles; cut a hang at 20000
  initial
  begin
    #(40 * 20000);
    bad_count++;
    end_of_test();
  end

endmodule : emulated_nv_byte_store_tb

`default_nettype wire

/* hdl/emulated_nv_byte_store.sv */
/*
  Emulated non-volatile byte store: a 32-byte volatile image reached
  through an index register and a data port, whole-image load and store
  commands to a 32-byte array, and a two-byte key guard on stores.
  Assumes the core presents at most one register access per cycle,
  with rd and wr never together, and that rst_i is the power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none

module emulated_nv_byte_store
(
  input  wire logic                   ref_clk_i,    // core clock, 25 MHz
  input  wire logic                   rst_i,        // power-on reset, sync, high
  input  wire nv_store_pkg::sfr_req_t sfr_i,        // register access
  output logic [7:0]                  sfr_rdata_o,  // read data, one cycle later
  output logic                        busy_o        // whole-image transfer running
);
  import nv_store_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // the whole module state lives in one packed struct
  typedef struct packed {
    logic [IMAGE_BYTES-1:0][7:0] nv_array;          // emulated non-volatile bytes
    logic [IMAGE_BYTES-1:0][7:0] image;             // volatile mirror
    logic [IDX_W-1:0]            index;             // byte_index_reg field
    nv_control_t                 ctrl;              // nv_control_reg
    guard_state_t                guard;             // guard_state
    logic [IDX_W-1:0]            xfer;              // byte under transfer
    logic [7:0]                  rdata;             // registered read data
  } state_t;

  state_t st_reg;                                   // registered state
  state_t st_next;                                  // next state

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // offset match, used for every register
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  // index after one auto-step, wrapping at the top address
  function automatic logic [IDX_W-1:0] step_index(input logic [IDX_W-1:0] idx);
    if (idx == IDX_TOP)
    begin
      step_index = IDX_RESET;
    end
    else
    begin
      step_index = idx + 5'h01;
    end
  endfunction : step_index

  logic       busy;                                 // a transfer owns the image
  logic       data_acc;                             // accepted data port access
  logic       data_wr;                              // data port write strobe
  logic       data_rd;                              // data port read strobe
  logic       ctrl_wr;                              // control register write
  logic       key_wr;                               // key register write
  logic       store_ok;                             // store request accepted
  logic       load_go;                              // load request accepted
  logic       store_req;                            // store bit written to one
  logic [7:0] sel_byte;                             // image byte at index

  assign busy     = st_reg.ctrl.image_load_cmd | st_reg.ctrl.image_store_cmd;
  assign data_wr  = sfr_i.wr & reg_hit(sfr_i.addr, BYTE_VALUE_OFF);
  assign data_rd  = sfr_i.rd & reg_hit(sfr_i.addr, BYTE_VALUE_OFF);
  // accesses during a transfer are dropped so the image stays coherent
  assign data_acc = (data_wr | data_rd) & st_reg.ctrl.nv_logic_on & ~busy;
  assign ctrl_wr  = sfr_i.wr & reg_hit(sfr_i.addr, NV_CONTROL_OFF);
  assign key_wr   = sfr_i.wr & reg_hit(sfr_i.addr, UNLOCK_KEY_OFF);
  assign sel_byte = st_reg.image[st_reg.index];
  // load has priority when both command bits are written together
  assign load_go  = ctrl_wr & sfr_i.wdata[2] & sfr_i.wdata[7] & ~busy;
  assign store_req = ctrl_wr & sfr_i.wdata[1] & sfr_i.wdata[7] & ~busy & ~sfr_i.wdata[2];
  assign store_ok = store_req & (st_reg.guard == GUARD_OPEN);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;

    // one byte per cycle while a transfer runs, 32 cycles in all
    if (st_reg.ctrl.image_load_cmd)
    begin
      st_next.image[st_reg.xfer] = st_reg.nv_array[st_reg.xfer];
      st_next.xfer               = st_reg.xfer + 5'h01;
      if (st_reg.xfer == IDX_TOP)
      begin
        st_next.ctrl.image_load_cmd = 1'b0;
      end
    end
    else if (st_reg.ctrl.image_store_cmd)
    begin
      st_next.nv_array[st_reg.xfer] = st_reg.image[st_reg.xfer];
      st_next.xfer                  = st_reg.xfer + 5'h01;
      if (st_reg.xfer == IDX_TOP)
      begin
        st_next.ctrl.image_store_cmd = 1'b0;
      end
    end

    // index register write, five bits kept
    if (sfr_i.wr && reg_hit(sfr_i.addr, BYTE_INDEX_OFF))
    begin
      st_next.index = sfr_i.wdata[IDX_W-1:0];
    end

    // data port write stores at the current index
    if (data_acc && data_wr)
    begin
      st_next.image[st_reg.index] = sfr_i.wdata;
    end

    // both directions of data port access may step the index
    if (data_acc && st_reg.ctrl.index_step_on)
    begin
      st_next.index = step_index(st_reg.index);
    end

    // control write: enable and step bits always, commands when allowed
    if (ctrl_wr)
    begin
      st_next.ctrl.nv_logic_on   = sfr_i.wdata[7];
      st_next.ctrl.index_step_on = sfr_i.wdata[0];
      if (load_go)
      begin
        st_next.ctrl.image_load_cmd = 1'b1;
        st_next.xfer                = IDX_RESET;
      end
      else if (store_ok)
      begin
        st_next.ctrl.image_store_cmd = 1'b1;
        st_next.xfer                 = IDX_RESET;
      end
    end

    // key sequence and protection state
    if (store_ok)
    begin
      st_next.guard = GUARD_LOCKED;
    end
    else if (store_req)
    begin
      st_next.guard = GUARD_DEAD;
    end
    else if (key_wr)
    begin
      unique case (st_reg.guard)
        GUARD_LOCKED:
        begin
          st_next.guard = (sfr_i.wdata == KEY_FIRST) ? GUARD_HALF : GUARD_DEAD;
        end
        GUARD_HALF:
        begin
          st_next.guard = (sfr_i.wdata == KEY_SECOND) ? GUARD_OPEN : GUARD_DEAD;
        end
        GUARD_OPEN:
        begin
          // any key byte while open spoils the sequence
          st_next.guard = GUARD_DEAD;
        end
        GUARD_DEAD:
        begin
          st_next.guard = GUARD_DEAD;
        end
        default:
        begin
          st_next.guard = GUARD_DEAD;
        end
      endcase
    end

    // read data is captured on the read strobe; unmapped offsets read zero
    if (sfr_i.rd)
    begin
      st_next.rdata = BYTE_RESET;
      if (reg_hit(sfr_i.addr, BYTE_INDEX_OFF))
      begin
        st_next.rdata = {3'b000, st_reg.index};
      end
      else if (data_rd && data_acc)
      begin
        st_next.rdata = sel_byte;
      end
      else if (reg_hit(sfr_i.addr, NV_CONTROL_OFF))
      begin
        st_next.rdata = st_reg.ctrl;
      end
      else if (reg_hit(sfr_i.addr, UNLOCK_KEY_OFF))
      begin
        st_next.rdata = {5'h00, st_reg.guard};
      end
    end

    // power-on reset clears control state; the array keeps its bytes
    if (rst_i)
    begin
      st_next.image = '0;
      st_next.index = IDX_RESET;
      st_next.ctrl  = '{nv_logic_on: 1'b0, rsv: CTRL_RSV_RESET, image_load_cmd: 1'b0,
                        image_store_cmd: 1'b0, index_step_on: 1'b0};
      st_next.guard = GUARD_LOCKED;
      st_next.xfer  = IDX_RESET;
      st_next.rdata = BYTE_RESET;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset is folded into the next value, so every field updates every edge
  always_ff @(posedge ref_clk_i)
  begin
    st_reg <= st_next;
  end

  assign sfr_rdata_o = st_reg.rdata;
  assign busy_o      = busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic step_go;                                    // accepted stepping access
  assign step_go = data_acc & st_reg.ctrl.index_step_on;

  index_wrap_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step_go && (st_reg.index == IDX_TOP) |=> (st_reg.index == IDX_RESET))
    else $error("index did not wrap to zero");

  index_step_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    step_go && (st_reg.index != IDX_TOP) && !(sfr_i.wr && reg_hit(sfr_i.addr, BYTE_INDEX_OFF))
    |=> (st_reg.index == $past(st_reg.index) + 5'h01))
    else $error("index did not step by one");

  image_write_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    data_acc && data_wr |=> (st_reg.image[$past(st_reg.index)] == $past(sfr_i.wdata)))
    else $error("data port write not stored");

  read_data_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    data_acc && data_rd |=> (sfr_rdata_o == $past(sel_byte)))
    else $error("data port read returned wrong byte");

  key_unlock_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    key_wr && !store_req && (st_reg.guard == GUARD_HALF) && (sfr_i.wdata == KEY_SECOND)
    |=> (st_reg.guard == GUARD_OPEN))
    else $error("correct key pair did not unlock");

  dead_lock_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (st_reg.guard == GUARD_DEAD) |=> (st_reg.guard == GUARD_DEAD))
    else $error("permanent lock was released");

  store_relock_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    store_ok |=> (st_reg.guard == GUARD_LOCKED) && st_reg.ctrl.image_store_cmd)
    else $error("store did not start and relock");

  load_done_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    load_go |-> ##32 st_reg.ctrl.image_load_cmd ##1 !st_reg.ctrl.image_load_cmd)
    else $error("load bit did not clear after 32 bytes");

  disabled_hold_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (data_wr || data_rd) && !st_reg.ctrl.nv_logic_on && !ctrl_wr
    |=> $stable(st_reg.image) && $stable(st_reg.index))
    else $error("disabled access changed image or index");

  guard_read_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    sfr_i.rd && reg_hit(sfr_i.addr, UNLOCK_KEY_OFF) && !sfr_i.wr
    |=> $stable(st_reg.guard) && (sfr_rdata_o[2:0] == st_reg.guard))
    else $error("key register read disturbed or misreported state");

  index_upper_a: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    sfr_i.rd && reg_hit(sfr_i.addr, BYTE_INDEX_OFF) |=> (sfr_rdata_o[7:5] == 3'b000))
    else $error("index upper bits not zero");

endmodule : emulated_nv_byte_store

`default_nettype wire

/* hdl/nv_store_pkg.sv */
/*
  Shared definitions for the emulated non-volatile byte store:
  special function register offsets, field layouts, key codes and the
  packed carriers used at the core-facing register port.
  Assumes a single core clock and one register access per cycle.
*/
`default_nettype none

package nv_store_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int          IMAGE_BYTES = 32;            // bytes in image and array
  localparam int          IDX_W       = 5;             // index field width
  localparam logic [4:0]  IDX_TOP     = 5'h1F;         // highest image address
  localparam logic [4:0]  IDX_RESET   = 5'h00;         // index after reset

  // ----------------------------------------------------------------
  // register offsets on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_INDEX_OFF  = 8'hB6;     // byte_index_reg
  localparam logic [7:0]  BYTE_VALUE_OFF  = 8'hC1;     // byte_value_port
  localparam logic [7:0]  NV_CONTROL_OFF  = 8'hC2;     // nv_control_reg
  localparam logic [7:0]  UNLOCK_KEY_OFF  = 8'hC3;     // unlock_key_reg

  // ----------------------------------------------------------------
  // key codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_FIRST       = 8'h55;     // first key byte
  localparam logic [7:0]  KEY_SECOND      = 8'hAA;     // second key byte
  localparam logic [7:0]  BYTE_RESET      = 8'h00;     // image and read data reset
  localparam logic [3:0]  CTRL_RSV_RESET  = 4'h0;      // unused control bits

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       nv_logic_on;                           // bit 7
    logic [3:0] rsv;                                   // bits 6:3, read zero
    logic       image_load_cmd;                        // bit 2
    logic       image_store_cmd;                       // bit 1
    logic       index_step_on;                         // bit 0
  } nv_control_t;

  // protection state reported in key register bits 2:0
  typedef enum logic [2:0] {
    GUARD_LOCKED,                                      // waiting for first key
    GUARD_HALF,                                        // first key seen
    GUARD_OPEN,                                        // one store allowed
    GUARD_DEAD                                         // locked until power-on
  } guard_state_t;

  // one register access from the core
  typedef struct packed {
    logic [7:0] addr;                                  // register offset
    logic       wr;                                    // write strobe, one cycle
    logic       rd;                                    // read strobe, one cycle
    logic [7:0] wdata;                                 // write data
  } sfr_req_t;

endpackage : nv_store_pkg

`default_nettype wire
